// >>> include/bcc_params.svh
`ifndef BCC_PARAMS_SVH
`define BCC_PARAMS_SVH
`define BCC_CTRL1_OFFSET    8'ha8
`define BCC_STATUS_OFFSET   8'ha9
`define BCC_BIT_REQ         15
`define BCC_EOC_HI          12
`define BCC_EOC_LO          10
`define BCC_BIT_TCHOKE      9
`define BCC_BIT_UCHOKE      8
`define BCC_BIT_RECOV       7
`define BCC_BIT_ENDACT      6
`define BCC_BIT_FAST        5
`define BCC_BIT_THROT       4
`define BCC_BIT_NTC         3
`define BCC_BIT_HOT         2
`define BCC_BIT_COLD        1
`define BCC_BIT_DIE         0
`define BCC_CTRL1_RESET     16'h800f
`define BCC_PROT_MASK       16'h9ff1
`define BCC_SM_RESET_MASK   16'h83e0
`define BCC_WRITE_MASK      16'h9fff
`define BCC_EOC_BASE_MA     20
`define BCC_EOC_STEP_MA     10
`define BCC_RECOV_FAST_US   180
`define BCC_RECOV_SLOW_MS   20
`define BCC_CLK_MHZ         250
`define BCC_RECOV_FAST_CYC  (`BCC_RECOV_FAST_US * `BCC_CLK_MHZ)
`define BCC_RECOV_SLOW_CYC  (`BCC_RECOV_SLOW_MS * 1000 * `BCC_CLK_MHZ + 1)
`endif

// >>> include/bcc_pkg.sv
package bcc_pkg;
  typedef enum logic [1:0] {
    BCC_ST_OFF     = 2'h0,
    BCC_ST_TRICKLE = 2'h1,
    BCC_ST_FAST    = 2'h2,
    BCC_ST_RSVD    = 2'h3
  } bcc_chg_state_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } bcc_bus_req_t;

  typedef struct packed {
    logic thermistor_absent_flag;
    logic battery_hot;
    logic battery_cold;
    logic die_hot;
  } bcc_faults_t;
endpackage : bcc_pkg

// >>> logic/bcc_recovery_timer.sv
`timescale 1ns/10ps
`include "bcc_params.svh"
module bcc_recovery_timer #(
  parameter int unsigned FAST_CYC = `BCC_RECOV_FAST_CYC,
  parameter int unsigned SLOW_CYC = `BCC_RECOV_SLOW_CYC
) (
  input  wire logic clock_i,
  input  wire logic rst_i,
  input  wire logic ce_i,
  input  wire logic slow_i,
  input  wire logic restart_i,
  output logic      done_o
);
  logic [31:0] cnt_q;
  logic [31:0] limit;

  initial begin
    if (FAST_CYC < 1 || SLOW_CYC < FAST_CYC) $error("bad recovery counts");
  end

  assign limit = slow_i ? SLOW_CYC : FAST_CYC;

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q <= 32'h0;
    end else if (ce_i) begin
      if (restart_i) begin
        cnt_q <= 32'h0;
      end else if (cnt_q < limit) begin
        cnt_q <= cnt_q + 32'h1;
      end
    end
  end

  assign done_o = (cnt_q >= limit);
endmodule : bcc_recovery_timer

// >>> logic/bcc_charger_ctrl.sv
// Design decision made here: strobed register access.
`timescale 1ns/10ps
`include "bcc_params.svh"
// Contract
// RQ1: bit 15 zero forces charge current off; one enables control; default one.
// RQ2: bits 12:10 pick end current, 20mA plus 10mA per code; default 000.
// RQ3: bit 9 enables thermal choking in trickle; default zero.
// RQ4: bit 8 enables usb current choking in trickle; default zero.
// RQ5: bit 7 picks recovery step-up constant, 180us or over 20ms.
// RQ6: bit 6 zero cuts current at charge end; one runs to timeout.
// RQ7: bit 5 permits fast charge, started only once conditions are valid.
// RQ8: fast permit held zero, writes ignored until fast-ready goes high.
// RQ9: bit 4 enables usb throttling during fast charge; default zero.
// RQ10: bit 3 makes charger obey thermistor-absent flag; default one.
// RQ11: bit 2 makes charger obey battery hot; default one.
// RQ12: bit 1 makes charger obey battery cold; default one.
// RQ13: bit 0 makes charger obey die over-temperature; default one.
// RQ14: protected bits change only while key unlocked; bits 3..1 always writable.
// RQ15: state machine reset restores bits 15 and 9..5 only.
// RQ16: request bit only asks; separate active status reports real charging.
// RQ17: state status 00 off, 01 trickle, 10 fast, 11 reserved.
// RQ18: bits 14 and 13 read zero and ignore writes.
module bcc_charger_ctrl
  import bcc_pkg::*;
#(
  parameter int unsigned FAST_CYC = `BCC_RECOV_FAST_CYC,
  parameter int unsigned SLOW_CYC = `BCC_RECOV_SLOW_CYC
) (
  input  wire logic                  clock_i,
  input  wire logic                  rst_i,
  input  wire logic                  ce_i,
  input  wire bcc_pkg::bcc_bus_req_t bus_i,
  output logic [15:0]                rdata_o,
  input  wire logic                  key_unlocked_i,
  input  wire logic                  sm_reset_i,
  input  wire logic                  fast_ready_i,
  input  wire logic                  conditions_ok_i,
  input  wire logic                  battery_full_i,
  input  wire logic                  timeout_i,
  input  wire logic                  choke_event_i,
  input  wire bcc_pkg::bcc_faults_t  faults_i,
  output logic                       charge_current_on_o,
  output logic [6:0]                 eoc_current_ma_o,
  output logic                       trickle_thermal_choke_en_o,
  output logic                       trickle_usb_choke_en_o,
  output logic                       fast_usb_throttle_en_o,
  output logic                       choke_recovered_o,
  output logic                       charging_active_status_o,
  output bcc_pkg::bcc_chg_state_t    charger_state_status_o
);
  import bcc_pkg::*;

  logic [15:0]    ctrl_q;
  logic [15:0]    rdata_q;
  logic           fast_ready_q;
  logic           ended_q;
  bcc_chg_state_t state_q;
  bcc_chg_state_t state_d;
  logic [15:0]    wmask;
  logic           fault;
  logic           run_ok;

  initial begin
    if (SLOW_CYC <= FAST_CYC) $error("slow recovery must exceed fast");
  end

  // protected bits need the key; reserved bits never take a write
  assign wmask = `BCC_WRITE_MASK & (key_unlocked_i ? 16'hffff : ~`BCC_PROT_MASK); // [RQ14] [RQ18]

  // sticky latch of the ready strobe so a later drop does not relock the bit
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      fast_ready_q <= 1'b0;
    end else if (ce_i) begin
      if (fast_ready_i) begin
        fast_ready_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_q <= `BCC_CTRL1_RESET; // [RQ1] [RQ2] [RQ10] [RQ11] [RQ12] [RQ13]
    end else if (ce_i) begin
      if (sm_reset_i) begin
        ctrl_q <= (ctrl_q & ~`BCC_SM_RESET_MASK) | (`BCC_CTRL1_RESET & `BCC_SM_RESET_MASK); // [RQ15]
      end else if (bus_i.wr && bus_i.addr == `BCC_CTRL1_OFFSET) begin
        ctrl_q <= (ctrl_q & ~wmask) | (bus_i.wdata & wmask); // [RQ14]
        if (!fast_ready_q) begin
          ctrl_q[`BCC_BIT_FAST] <= 1'b0; // [RQ8]
        end
      end else if (!fast_ready_q) begin
        ctrl_q[`BCC_BIT_FAST] <= 1'b0; // [RQ8]
      end
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_q <= 16'h0;
    end else if (ce_i) begin
      if (bus_i.rd) begin
        case (bus_i.addr)
          `BCC_CTRL1_OFFSET:  rdata_q <= ctrl_q;
          `BCC_STATUS_OFFSET: rdata_q <= {charging_active_status_o, 1'b0, state_q, 12'h0}; // [RQ16] [RQ17]
          default:            rdata_q <= 16'h0;
        endcase
      end else begin
        rdata_q <= 16'h0;
      end
    end
  end
  assign rdata_o = rdata_q;

  // masked fault sources
  assign fault = (faults_i.thermistor_absent_flag & ctrl_q[`BCC_BIT_NTC])  // [RQ10]
               | (faults_i.battery_hot  & ctrl_q[`BCC_BIT_HOT])            // [RQ11]
               | (faults_i.battery_cold & ctrl_q[`BCC_BIT_COLD])           // [RQ12]
               | (faults_i.die_hot      & ctrl_q[`BCC_BIT_DIE]);           // [RQ13]

  assign run_ok = ctrl_q[`BCC_BIT_REQ] && conditions_ok_i && !fault && !ended_q; // [RQ1] [RQ16]

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      ended_q <= 1'b0;
    end else if (ce_i) begin
      if (!ctrl_q[`BCC_BIT_REQ]) begin
        ended_q <= 1'b0;
      end else if (state_q != BCC_ST_OFF &&
                   ((battery_full_i && !ctrl_q[`BCC_BIT_ENDACT]) || timeout_i)) begin
        ended_q <= 1'b1; // [RQ6]
      end
    end
  end

  always_comb begin
    state_d = BCC_ST_OFF;
    case (state_q)
      BCC_ST_OFF, BCC_ST_TRICKLE, BCC_ST_FAST: begin
        if (!run_ok) begin
          state_d = BCC_ST_OFF;
        end else if (ctrl_q[`BCC_BIT_FAST]) begin
          state_d = BCC_ST_FAST; // [RQ7]
        end else begin
          state_d = BCC_ST_TRICKLE;
        end
      end
      default: state_d = BCC_ST_OFF;
    endcase
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= BCC_ST_OFF;
    end else if (ce_i) begin
      state_q <= state_d; // [RQ17]
    end
  end

  // choke recovery restarts on each choke event
  bcc_recovery_timer #(
    .FAST_CYC (FAST_CYC),
    .SLOW_CYC (SLOW_CYC)
  ) u_recov (
    .clock_i   (clock_i),
    .rst_i     (rst_i),
    .ce_i      (ce_i),
    .slow_i    (ctrl_q[`BCC_BIT_RECOV]), // [RQ5]
    .restart_i (choke_event_i),
    .done_o    (choke_recovered_o)
  );

  assign charging_active_status_o   = (state_q != BCC_ST_OFF); // [RQ16]
  assign charger_state_status_o     = state_q;
  assign charge_current_on_o        = charging_active_status_o; // [RQ1] [RQ6]
  assign eoc_current_ma_o           = 7'(`BCC_EOC_BASE_MA) +
                                      7'(ctrl_q[`BCC_EOC_HI:`BCC_EOC_LO]) * 7'(`BCC_EOC_STEP_MA); // [RQ2]
  assign trickle_thermal_choke_en_o = ctrl_q[`BCC_BIT_TCHOKE] && state_q == BCC_ST_TRICKLE; // [RQ3]
  assign trickle_usb_choke_en_o     = ctrl_q[`BCC_BIT_UCHOKE] && state_q == BCC_ST_TRICKLE; // [RQ4]
  assign fast_usb_throttle_en_o     = ctrl_q[`BCC_BIT_THROT] && state_q == BCC_ST_FAST;     // [RQ9]

  a_fast_locked: assert property (@(posedge clock_i) disable iff (rst_i) // [RQ8]
    !fast_ready_q |-> !ctrl_q[`BCC_BIT_FAST]) else $error("fast permit set before ready");

  a_prot_write: assert property (@(posedge clock_i) disable iff (rst_i) // [RQ14]
    ce_i && bus_i.wr && bus_i.addr == `BCC_CTRL1_OFFSET && !key_unlocked_i && !sm_reset_i
    |=> ctrl_q[15] == $past(ctrl_q[15]) && ctrl_q[0] == $past(ctrl_q[0])) else $error("protected bit changed");

  a_open_write: assert property (@(posedge clock_i) disable iff (rst_i) // [RQ14]
    ce_i && bus_i.wr && bus_i.addr == `BCC_CTRL1_OFFSET && !sm_reset_i
    |=> ctrl_q[3:1] == $past(bus_i.wdata[3:1])) else $error("open bits not written");

  a_rsvd_zero: assert property (@(posedge clock_i) disable iff (rst_i) // [RQ18]
    ctrl_q[14:13] == 2'h0) else $error("reserved bits nonzero");

  a_sm_reset: assert property (@(posedge clock_i) disable iff (rst_i) // [RQ15]
    ce_i && sm_reset_i |=> ctrl_q[15] && ctrl_q[9:5] == 5'h0
      && ctrl_q[12:10] == $past(ctrl_q[12:10])) else $error("sm reset wrong");

  a_req_off: assert property (@(posedge clock_i) disable iff (rst_i) // [RQ1]
    ce_i && !ctrl_q[`BCC_BIT_REQ] |=> !charge_current_on_o) else $error("current on while request off");

  a_no_fast: assert property (@(posedge clock_i) disable iff (rst_i) // [RQ7]
    ce_i && !ctrl_q[`BCC_BIT_FAST] |=> state_q != BCC_ST_FAST) else $error("fast without permit");

  a_state_code: assert property (@(posedge clock_i) disable iff (rst_i) // [RQ17]
    state_q != BCC_ST_RSVD) else $error("reserved state code");

  a_die_fault: assert property (@(posedge clock_i) disable iff (rst_i) // [RQ13]
    ce_i && faults_i.die_hot && ctrl_q[`BCC_BIT_DIE] |=> !charging_active_status_o) else $error("die fault ignored");

  a_eoc_value: assert property (@(posedge clock_i) disable iff (rst_i) // [RQ2]
    ctrl_q[12:10] == 3'h7 |-> eoc_current_ma_o == 7'd90) else $error("eoc current wrong");

  a_read_data: assert property (@(posedge clock_i) disable iff (rst_i)
    ce_i && bus_i.rd && bus_i.addr == `BCC_CTRL1_OFFSET ##1 1'b1 |-> rdata_o == $past(ctrl_q))
    else $error("read data wrong");
endmodule : bcc_charger_ctrl

// >>> verif/bcc_charger_ctrl_tb.sv
`timescale 1ns/10ps
`include "bcc_params.svh"
module bcc_charger_ctrl_tb;
  import bcc_pkg::*;
  localparam int LIMIT = 3000;
  logic                  clock_i = 1'b0;
  logic                  rst_i   = 1'b1;
  logic                  ce_i    = 1'b1;
  bcc_bus_req_t          bus     = '0;
  logic [15:0]           rdata_o;
  logic                  key = 1'b0, smr = 1'b0, fready = 1'b0, cond = 1'b0;
  logic                  full = 1'b0, tmo = 1'b0, choke = 1'b0;
  bcc_faults_t           faults  = '0;
  logic                  on, tchk, uchk, thr, rec, act;
  logic [6:0]            eoc;
  bcc_chg_state_t        st;
  int                    errors = 0, comparisons = 0, cycles = 0;

  // short recovery counts keep the run brief; expectations below follow them
  bcc_charger_ctrl #(.FAST_CYC(4), .SLOW_CYC(10)) bcc_charger_ctrl_inst (
    .clock_i(clock_i), .rst_i(rst_i), .ce_i(ce_i), .bus_i(bus), .rdata_o(rdata_o),
    .key_unlocked_i(key), .sm_reset_i(smr), .fast_ready_i(fready), .conditions_ok_i(cond),
    .battery_full_i(full), .timeout_i(tmo), .choke_event_i(choke), .faults_i(faults),
    .charge_current_on_o(on), .eoc_current_ma_o(eoc), .trickle_thermal_choke_en_o(tchk),
    .trickle_usb_choke_en_o(uchk), .fast_usb_throttle_en_o(thr), .choke_recovered_o(rec),
    .charging_active_status_o(act), .charger_state_status_o(st));

  always #2 clock_i = ~clock_i;

  task automatic report_and_stop();
    if (errors == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop

  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      errors = errors + 1;
      report_and_stop();
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons = comparisons + 1;
    if (seen !== exp) begin
      errors = errors + 1;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock_i);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock_i);
    bus.wr <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rdchk(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clock_i);
    bus <= '{addr: a, wdata: 16'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clock_i);
    bus.rd <= 1'b0;
    #1 chk(rdata_o, exp);
  endtask : rdchk

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask : wait_cyc

  initial begin
    repeat (6) @(posedge clock_i);
    rst_i <= 1'b0;
    rdchk(`BCC_CTRL1_OFFSET, 16'h800f);
    chk(16'(eoc), 16'd20);
    rdchk(8'h10, 16'h0000);
    wr(`BCC_CTRL1_OFFSET, 16'h0000);
    rdchk(`BCC_CTRL1_OFFSET, 16'h8001);
    wr(`BCC_CTRL1_OFFSET, 16'hffff);
    rdchk(`BCC_CTRL1_OFFSET, 16'h800f);
    key <= 1'b1;
    cond <= 1'b1;
    wr(`BCC_CTRL1_OFFSET, 16'hffff);
    rdchk(`BCC_CTRL1_OFFSET, 16'h9fdf);
    wait_cyc(3);
    chk(16'(st), 16'(BCC_ST_TRICKLE));
    chk({14'h0, tchk, uchk}, 16'h0003);
    chk(16'(thr), 16'h0);
    for (int i = 0; i < 8; i++) begin
      wr(`BCC_CTRL1_OFFSET, 16'h800f | 16'(i << 10));
      #1;
      chk(16'(eoc), 16'(20 + 10 * i));
    end
    fready <= 1'b1;
    wr(`BCC_CTRL1_OFFSET, 16'h803f);
    rdchk(`BCC_CTRL1_OFFSET, 16'h803f);
    wait_cyc(3);
    chk(16'(st), 16'(BCC_ST_FAST));
    rdchk(`BCC_STATUS_OFFSET, 16'ha000);
    chk({13'h0, act, on, thr}, 16'h0007);
    chk({14'h0, tchk, uchk}, 16'h0000);
    cond <= 1'b0;
    wait_cyc(3);
    chk({13'h0, act, st}, 16'h0000);
    cond <= 1'b1;
    // fault order in the struct matches monitor bits 3..0
    for (int i = 0; i < 4; i++) begin
      wr(`BCC_CTRL1_OFFSET, 16'h800f);
      faults <= bcc_faults_t'(4'(1 << i));
      wait_cyc(3);
      chk(16'(act), 16'h0);
      wr(`BCC_CTRL1_OFFSET, 16'h800f & ~16'(1 << i));
      wait_cyc(3);
      chk(16'(act), 16'h1);
      faults <= '0;
    end
    wr(`BCC_CTRL1_OFFSET, 16'h000f);
    wait_cyc(3);
    chk({14'h0, on, act}, 16'h0000);
    wr(`BCC_CTRL1_OFFSET, 16'h800f);
    full <= 1'b1;
    wait_cyc(3);
    chk(16'(act), 16'h0);
    wr(`BCC_CTRL1_OFFSET, 16'h000f);
    wr(`BCC_CTRL1_OFFSET, 16'h804f);
    wait_cyc(3);
    chk(16'(act), 16'h1);
    tmo <= 1'b1;
    wait_cyc(3);
    chk(16'(act), 16'h0);
    tmo <= 1'b0;
    full <= 1'b0;
    wr(`BCC_CTRL1_OFFSET, 16'h808f);
    choke <= 1'b1;
    @(posedge clock_i);
    choke <= 1'b0;
    wait_cyc(6);
    chk(16'(rec), 16'h0);
    wait_cyc(10);
    chk(16'(rec), 16'h1);
    wr(`BCC_CTRL1_OFFSET, 16'h800f);
    choke <= 1'b1;
    @(posedge clock_i);
    choke <= 1'b0;
    wait_cyc(1);
    chk(16'(rec), 16'h0);
    wait_cyc(8);
    chk(16'(rec), 16'h1);
    wr(`BCC_CTRL1_OFFSET, 16'hffff);
    rdchk(`BCC_CTRL1_OFFSET, 16'h9fff);
    // a write while the clock enable is low must leave the register untouched
    ce_i <= 1'b0;
    wr(`BCC_CTRL1_OFFSET, 16'h800f);
    ce_i <= 1'b1;
    rdchk(`BCC_CTRL1_OFFSET, 16'h9fff);
    smr <= 1'b1;
    @(posedge clock_i);
    smr <= 1'b0;
    rdchk(`BCC_CTRL1_OFFSET, 16'h9c1f);
    report_and_stop();
  end
endmodule : bcc_charger_ctrl_tb
